// ### common/ecs_pkg.sv
package ecs_pkg;
  localparam int SMP_W        = 16;
  localparam int NUM_CH       = 3;
  localparam int SET_BITS     = 54;
  localparam int TRIM_W       = 8;
  localparam logic [7:0] TRIM_INIT = 8'h80;
  localparam logic [9:0] TRIM_BASE = 10'h300;
  localparam int TRIM_SHIFT   = 10;
  localparam int VOLT_GAIN_SH = 2;
  localparam int DC_SHIFT     = 8;
  localparam int PWR_SHIFT    = 20;
  localparam int ACC_W        = 32;
  localparam int TAP_BIT      = 11;
  localparam int STEP_DIV_W   = 6;
  localparam int FIFO_DEPTH   = 16;
  // Settings memory layout
  localparam int POS_VTRIM    = 0;
  localparam int POS_PTRIM    = 8;
  localparam int POS_STRIM    = 16;
  localparam int POS_GAIN     = 24;
  localparam logic [1:0] GAIN_INIT = 2'h3;
  localparam logic [5:0] MODE_PROG = 6'h3f;
  // Register map, byte addresses
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_TRIM   = 8'h04;
  localparam logic [7:0] OFS_SET_LO = 8'h08;
  localparam logic [7:0] OFS_SET_HI = 8'h0c;
  localparam logic [7:0] OFS_ENERGY = 8'h10;
  localparam logic [7:0] OFS_PULSES = 8'h14;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLV   = 2'h2;

  typedef struct packed {
    logic signed [SMP_W-1:0] sec;
    logic signed [SMP_W-1:0] pri;
    logic signed [SMP_W-1:0] volt;
  } ecs_sample_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_FILT  = 2'h1,
    ST_SCALE = 2'h3,
    ST_ACC   = 2'h2
  } ecs_state_e;
endpackage

// ### hw/ecs_top.sv
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module ecs_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Ready from a flop; one slot held back so it never overruns
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_ready <= 1'b0;
    end else begin
      in_ready <= (count + (AW+1)'(push) - (AW+1)'(pop))
                  < (AW+1)'(DEPTH - 1);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

module ecs_top (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  // Decimated samples
  input  wire logic                sample_valid,
  input  wire ecs_pkg::ecs_sample_s sample_data,
  output logic                     sample_ready,
  // Serial configuration pins
  input  wire logic                cfg_enable,
  input  wire logic                cfg_clock,
  input  wire logic                cfg_data,
  // Energy outputs
  output logic                     led_pulse,
  output logic                     stepper_p,
  output logic                     stepper_n,
  // AXI4-Lite write
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);
  import ecs_pkg::*;

  logic [1:0]          rst_sync;
  logic                rst_n;
  logic [2:0]          en_sync;
  logic [2:0]          clk_sync;
  logic [2:0]          dat_sync;
  logic                ser_edge;
  logic [6:0]          ser_shift;
  logic [2:0]          ser_count;
  logic                ser_fire;
  logic                prog_en;
  logic [SET_BITS-1:0] shadow;
  logic [SET_BITS-1:0] perm;
  logic [SET_BITS-1:0] settings;
  logic [7:0]          aw_addr;
  logic                aw_held;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic                w_held;
  logic                bus_wr;
  logic                fifo_valid;
  ecs_sample_s         fifo_data;
  ecs_sample_s         cur;
  ecs_state_e          state;
  logic signed [21:0]  scaled [NUM_CH];
  logic [5:0]          gain [NUM_CH];
  logic [7:0]          code [NUM_CH];
  logic signed [43:0]  pwr_pri;
  logic signed [43:0]  pwr_sec;
  logic signed [43:0]  pwr_sel;
  logic [ACC_W-1:0]    energy;
  logic [ACC_W-1:0]    pulses;
  logic [STEP_DIV_W-1:0] step_cnt;
  logic                led_q;

  // Reset release through two flops
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      en_sync  <= 3'h0;
      clk_sync <= 3'h0;
      dat_sync <= 3'h0;
    end else begin
      en_sync  <= {en_sync[1:0], cfg_enable};
      clk_sync <= {clk_sync[1:0], cfg_clock};
      dat_sync <= {dat_sync[1:0], cfg_data};
    end
  end
  assign ser_edge = clk_sync[1] && !clk_sync[2] && en_sync[1];

  // Serial command: data bit, address, then latching bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ser_shift <= 7'h0;
      ser_count <= 3'h0;
    end else if (!en_sync[1]) begin
      ser_count <= 3'h0;
    end else if (ser_edge) begin
      ser_shift <= {ser_shift[5:0], dat_sync[1]};
      ser_count <= ser_count + 3'h1;
    end
  end
  assign ser_fire = ser_edge && (ser_count == 3'h7);

  // Settings memory; permanent bits only ever set
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shadow  <= '0;
      perm    <= '0;
      prog_en <= 1'b0;
      shadow[POS_VTRIM +: TRIM_W] <= TRIM_INIT;
      shadow[POS_PTRIM +: TRIM_W] <= TRIM_INIT;
      shadow[POS_STRIM +: TRIM_W] <= TRIM_INIT;
      shadow[POS_GAIN +: 2]       <= GAIN_INIT;
    end else begin
      if (ser_fire) begin
        if (ser_shift[5:0] == MODE_PROG) begin
          prog_en <= ser_shift[6];
        end else if (ser_shift[5:0] < 6'(SET_BITS)) begin
          shadow[ser_shift[5:0]] <= ser_shift[6];
          if (prog_en && ser_shift[6]) begin
            perm[ser_shift[5:0]] <= 1'b1;
          end
        end
      end
      if (bus_wr && aw_addr == OFS_CTRL && w_strb[0]) begin
        prog_en <= w_data[0];
      end
      if (bus_wr && aw_addr == OFS_TRIM) begin
        for (int b = 0; b < 4; b++) begin
          if (w_strb[b]) begin
            shadow[8*b +: 8] <= w_data[8*b +: 8];
          end
        end
      end
    end
  end
  assign settings = shadow | perm;

  // AXI4-Lite write: address and data taken in either order
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
    end else begin
      s_axi_awready <= s_axi_awvalid && !aw_held && !s_axi_awready;
      s_axi_wready  <= s_axi_wvalid && !w_held && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
      end
      if (bus_wr) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == OFS_CTRL || aw_addr == OFS_TRIM)
                        ? RESP_OKAY : RESP_SLV;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign bus_wr = aw_held && w_held && !s_axi_bvalid;

  // AXI4-Lite read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        case (s_axi_araddr)
          OFS_CTRL:   s_axi_rdata <= {31'h0, prog_en};
          OFS_TRIM:   s_axi_rdata <= settings[31:0];
          OFS_SET_LO: s_axi_rdata <= settings[31:0];
          OFS_SET_HI: s_axi_rdata <= {10'h0, settings[SET_BITS-1:32]};
          OFS_ENERGY: s_axi_rdata <= energy;
          OFS_PULSES: s_axi_rdata <= pulses;
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_SLV;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Sample buffer; datapath drains only when idle
  ecs_fifo #(
    .WIDTH ($bits(ecs_sample_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (sample_valid),
    .in_data   (sample_data),
    .in_ready  (sample_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (state == ST_IDLE)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cur   <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (fifo_valid) begin
            cur   <= fifo_data;
            state <= ST_FILT;
          end
        end
        ST_FILT:  state <= ST_SCALE;
        ST_SCALE: state <= ST_ACC;
        ST_ACC:   state <= ST_IDLE;
        default:  state <= ST_IDLE;
      endcase
    end
  end

  // Codes sampled at the scale step, so a change before that step hits the sample in flight
  assign code[0] = settings[POS_VTRIM +: TRIM_W];
  assign code[1] = settings[POS_PTRIM +: TRIM_W];
  assign code[2] = settings[POS_STRIM +: TRIM_W];
  assign gain[0] = 6'(1 << VOLT_GAIN_SH);
  assign gain[1] = {{1'b0, settings[POS_GAIN +: 2]} + 3'h1, 3'h0};
  assign gain[2] = gain[1];

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic signed [SMP_W-1:0] x;
    logic signed [SMP_W+7:0] dc;
    logic signed [SMP_W:0]   y;
    logic signed [27:0]      prod;
    assign x    = cur[c*SMP_W +: SMP_W];
    assign prod = y * $signed({1'b0, TRIM_BASE + {2'h0, code[c]}});
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        dc     <= '0;
        y      <= '0;
        scaled[c] <= '0;
      end else if (state == ST_FILT) begin
        // High-pass: track mean with a leaky integrator
        y  <= (SMP_W+1)'(x - (dc >>> DC_SHIFT));
        dc <= dc + (SMP_W+8)'(x - (dc >>> DC_SHIFT));
      end else if (state == ST_SCALE) begin
        scaled[c] <= 22'(prod >>> TRIM_SHIFT) * $signed({1'b0, gain[c]});
      end
    end
  end

  // Product of scaled channels carries Kv times Ki
  assign pwr_pri = 44'(scaled[0] * scaled[1]);
  assign pwr_sec = 44'(scaled[0] * scaled[2]);
  // Larger of the two powers counts, so a bypassed shunt is caught
  assign pwr_sel = (pwr_sec > pwr_pri) ? pwr_sec : pwr_pri;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      energy <= '0;
    end else if (state == ST_ACC && pwr_sel > 0) begin
      energy <= energy + ACC_W'(pwr_sel >>> PWR_SHIFT);
    end
  end

  // Output pulses; the tap bit toggles at a rate set by energy
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      led_q     <= 1'b0;
      led_pulse <= 1'b0;
      step_cnt  <= '0;
      pulses    <= '0;
      stepper_p <= 1'b0;
      stepper_n <= 1'b1;
    end else begin
      led_q     <= energy[TAP_BIT];
      led_pulse <= energy[TAP_BIT];
      if (energy[TAP_BIT] && !led_q) begin
        step_cnt <= step_cnt + 1'b1;
        pulses   <= pulses + 1'b1;
      end
      stepper_p <= step_cnt[STEP_DIV_W-1];
      stepper_n <= !step_cnt[STEP_DIV_W-1];
    end
  end
endmodule

`default_nettype wire

// ### verification/ecs_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ecs_chk
  import ecs_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rstn,
  // Stream and energy outputs
  input wire logic        sample_valid,
  input wire logic        sample_ready,
  input wire logic        led_pulse,
  input wire logic        stepper_p,
  input wire logic        stepper_n,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Idle span; 80 covers a full FIFO drained at one per 4 cycles
  logic [6:0] idle_cnt;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) idle_cnt <= 7'h0;
    else if (sample_valid && sample_ready) idle_cnt <= 7'h0;
    else if (idle_cnt != 7'h7f) idle_cnt <= idle_cnt + 7'h1;
  end
  AST_LED_QUIET: assert property (idle_cnt >= 7'h50 |-> $stable(led_pulse))
    else $error("led moved with no samples");
  AST_STEP_COMPL: assert property (stepper_n == !stepper_p)
    else $error("stepper outputs not complementary");
  AST_STEP_FOLLOW: assert property ($stable(led_pulse) [*6] |=> $stable(stepper_p))
    else $error("stepper moved without led edge");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_W_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:4] s_axi_bvalid)
    else $error("write response late");
  AST_R_NEXT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_R_ERR: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLV
    |-> s_axi_rdata == 32'h0)
    else $error("error read with data");
  AST_AW_ONCE: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write address taken");
endmodule
bind ecs_top ecs_chk ecs_chk_i (.*);
`default_nettype wire

// ### verification/ecs_sample_src.sv
`timescale 1ns/1ps
`default_nettype none
module ecs_sample_src
  import ecs_pkg::*;
(
  // Clock and reset
  input wire logic             clk,
  input wire logic             rst_n,
  // Bench control
  input wire logic             en,
  input wire logic             slow,
  input wire logic [15:0]      amp,
  output int                   n_taken,
  // Sample stream
  output logic                 sample_valid,
  output ecs_pkg::ecs_sample_s sample_data,
  input wire logic             sample_ready
);
  logic       neg;
  logic [1:0] gap;
  // Alternating sign keeps the stream free of DC
  function automatic ecs_sample_s mk(input logic n);
    mk.volt = n ? -$signed(amp) : $signed(amp);
    mk.pri = mk.volt;
    mk.sec = 16'sh0;
  endfunction
  // Idle data toggles so a stale word is never mistaken for a sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_valid <= 1'b0;
      sample_data <= 48'h0;
      neg <= 1'b0;
      gap <= 2'h0;
      n_taken <= 0;
    end else if (sample_valid && sample_ready) begin
      n_taken <= n_taken + 1;
      neg <= !neg;
      gap <= slow ? 2'h3 : 2'h0;
      sample_valid <= en && !slow;
      sample_data <= (en && !slow) ? mk(!neg) : ~sample_data;
    end else if (!sample_valid) begin
      if (gap != 2'h0) gap <= gap - 2'h1;
      sample_valid <= en && gap == 2'h0;
      sample_data <= (en && gap == 2'h0) ? mk(neg) : ~sample_data;
    end
  end
endmodule
`default_nettype wire

// ### verification/energy_calibration_scaler_test.sv
`timescale 1ns/1ps
`default_nettype none
module energy_calibration_scaler_test;
  import ecs_pkg::*;
  logic        clk_sys = 1'b0, rstn = 1'b0;
  logic        sample_valid, sample_ready, led_pulse, stepper_p, stepper_n;
  ecs_sample_s sample_data;
  logic        cfg_enable = 1'b0, cfg_clock = 1'b0, cfg_data = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic        src_en = 1'b0, src_slow = 1'b0, full_seen = 1'b0;
  logic [15:0] src_amp = 16'h07d0;
  int          n_taken, n_errors = 0, samples_checked = 0, seed = 755;

  always #12.5 clk_sys = ~clk_sys;

  ecs_top ecs_top_i (.*);
  ecs_sample_src ecs_sample_src_i (.clk(clk_sys), .rst_n(rstn), .en(src_en),
    .slow(src_slow), .amp(src_amp), .n_taken(n_taken),
    .sample_valid(sample_valid), .sample_data(sample_data),
    .sample_ready(sample_ready));

  always @(posedge clk_sys)
    if (sample_valid === 1'b1 && sample_ready === 1'b0 && rstn) full_seen <= 1'b1;

  task automatic chk(input string nm, input logic [31:0] e, g,
                     input logic [31:0] tol = 32'h0);
    samples_checked++;
    if (((g - e + tol) <= 2 * tol) !== 1'b1) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic [15:0] cal_codes(input int r_milli);
    int f;
    f = r_milli - 768000;
    cal_codes[7:0] = 8'(f / 1000);
    cal_codes[15:8] = (f + 500) / 1000 > 255 ? 8'hff : 8'((f + 500) / 1000);
  endfunction

  // Relative power from trims and gain select
  function automatic int pwr(input logic [31:0] w);
    return (768 + int'(w[7:0])) * (768 + int'(w[15:8])) * (int'(w[25:24]) + 1);
  endfunction

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk_sys);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    repeat ($unsigned($random(seed)) % 3) @(posedge clk_sys);
    s_axi_bready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    repeat ($unsigned($random(seed)) % 3) @(posedge clk_sys);
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Serial clock idles low between commands
  task automatic cfg_cmd(input logic d, input logic [5:0] a);
    logic [7:0] b;
    b = {d, a, 1'b0};
    cfg_enable <= 1'b1;
    for (int i = 7; i >= 0; i--) begin
      cfg_data <= b[i];
      repeat (4) @(posedge clk_sys);
      cfg_clock <= 1'b1;
      repeat (4) @(posedge clk_sys);
      cfg_clock <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    cfg_enable <= 1'b0;
    cfg_data <= ~cfg_data;
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic stream(input int n);
    int tgt;
    tgt = n_taken + n;
    src_en <= 1'b1;
    while (n_taken < tgt) @(posedge clk_sys);
    src_en <= 1'b0;
    repeat (100) @(posedge clk_sys);
    chk("sample_ready", 32'h1, {31'h0, sample_ready});
  endtask

  initial begin
    logic [31:0] w, rd, sv, e0, e1, dp, dc;
    logic [1:0]  r;
    longint      pp, pc;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    axi_rd(OFS_SET_LO, rd, r);
    chk("set_lo", {6'h0, GAIN_INIT, {3{TRIM_INIT}}}, rd);
    chk("rresp_okay", {30'h0, RESP_OKAY}, {30'h0, r});
    axi_rd(OFS_SET_HI, rd, r);
    chk("set_hi", 32'h0, rd);
    $display("test reset done");
    axi_wr(8'h1c, 32'h1, 4'hf, r);
    chk("bresp_unmapped", {30'h0, RESP_SLV}, {30'h0, r});
    axi_wr(OFS_ENERGY, 32'h1, 4'hf, r);
    chk("bresp_readonly", {30'h0, RESP_SLV}, {30'h0, r});
    axi_rd(8'h20, rd, r);
    chk("rresp_unmapped", {30'h0, RESP_SLV}, {30'h0, r});
    chk("rdata_unmapped", 32'h0, rd);
    w = $random(seed);
    axi_wr(OFS_TRIM, w, 4'h2, r);
    axi_rd(OFS_SET_LO, rd, r);
    chk("lane_primary", {6'h0, GAIN_INIT, TRIM_INIT, w[15:8], TRIM_INIT}, rd);
    $display("test bus done");
    sv = rd;
    cfg_cmd(~sv[1], 6'h01);
    sv[1] = ~sv[1];
    axi_rd(OFS_SET_LO, rd, r);
    chk("serial_latch", sv, rd);
    cfg_cmd(1'b1, 6'h37);
    axi_rd(OFS_SET_LO, rd, r);
    chk("serial_ignored", sv, rd);
    cfg_cmd(1'b1, MODE_PROG);
    axi_rd(OFS_CTRL, rd, r);
    chk("prog_enable", 32'h1, rd);
    cfg_cmd(1'b1, 6'h30);
    axi_wr(OFS_CTRL, 32'h0, 4'h1, r);
    chk("bresp_ctrl", {30'h0, RESP_OKAY}, {30'h0, r});
    cfg_cmd(1'b0, 6'h30);
    axi_rd(OFS_SET_HI, rd, r);
    chk("permanent_bit", 32'h00010000, rd);
    $display("test serial done");
    for (int k = 0; k < 4; k++) begin
      w = (k == 0) ? 32'h0 : {6'h0, 2'(k - 1), 8'($random(seed)), 16'hffff};
      if (k == 3) w[25:24] = 2'h3;
      if (k == 2) w[15:0] = cal_codes(768000 + int'($unsigned($random(seed)) % 256000));
      axi_wr(OFS_TRIM, w, 4'hf, r);
      axi_rd(OFS_SET_LO, rd, r);
      chk("trim_readback", w, rd);
      src_slow <= (k == 2);
      axi_rd(OFS_ENERGY, e0, r);
      stream(400);
      axi_rd(OFS_ENERGY, e1, r);
      dc = e1 - e0;
      pc = pwr(w);
      if (k > 0) begin
        sv = 32'(pc * 1000 / pp);
        rd = dc * 1000 / dp;
        chk("power_ratio", sv, rd, 32'h1e);
      end
      pp = pc;
      dp = dc;
      $display("test energy run done");
    end
    chk("fifo_full", 32'h1, {31'h0, full_seen});
    axi_rd(OFS_ENERGY, e1, r);
    chk("led_level", {31'h0, e1[11]}, {31'h0, led_pulse});
    axi_rd(OFS_PULSES, rd, r);
    chk("stepper_p", {31'h0, rd[5]}, {31'h0, stepper_p});
    chk("stepper_n", {31'h0, ~rd[5]}, {31'h0, stepper_n});
    give_verdict;
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    give_verdict;
  end
endmodule
`default_nettype wire
